/* File: bench/cis_sequencer_tb.sv */
/*
 Self-checking bench of the interrupt sequencer: APB master, pipeline driver.
 Assumes the stack model answers reads one cycle after the strobe.
*/
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
   $display("MISMATCH t=%0t %s", $time, m); end end
module cis_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [4:0] DN = 5'h10, SEI = 5'h18, MSK = 5'h14, RET = 5'h02, SLP = 5'h11;
   logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, ext_req, core_hold, tk, err;
   logic [7:0] paddr, stk_rdata, flag_evt, level_cond;
   logic [31:0] pwdata, prdata, rd;
   cis_pkg::cis_pipe_in_t pipe_i;
   cis_pkg::cis_seq_out_t seq_o;
   int mismatches = 0;
   int n_compared = 0;
   int n;
   cis_sequencer cis_sequencer_i (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .external_request_zero(ext_req), .flag_evt(flag_evt),
      .level_cond(level_cond), .pipe_i(pipe_i), .stk_rdata(stk_rdata), .seq_o(seq_o),
      .core_hold(core_hold));
   cis_stack_model cis_stack_model_i (.mclk(mclk), .seq_o(seq_o), .stk_rdata(stk_rdata));
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   task automatic conclude();
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int g;
      g = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         g++;
      end while (pready !== 1'b1 && g < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic instr(input logic [4:0] ctl, input logic [10:0] pc);
      @(posedge mclk);
      pipe_i <= {ctl, pc};
      @(negedge mclk);
      tk = seq_o.taken;
      @(posedge mclk);
      pipe_i <= {4'h0, ctl[0], pc};
   endtask : instr
   task automatic flag(input logic [7:0] f);
      @(posedge mclk);
      flag_evt <= f;
      @(posedge mclk);
      flag_evt <= 8'h00;
   endtask : flag
   task automatic lat();
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (seq_o.pc_load !== 1'b1 && n < 20);
   endtask : lat
   task automatic enter(input logic [4:0] ctl, input logic [10:0] pc, vec, input int cyc);
      instr(ctl, pc);
      `CHK(tk, 1'b1, "no take")
      lat();
      `CHK(n, cyc, "entry cycles")
      `CHK(seq_o.pc_val, vec, "vector")
      `CHK(core_hold, 1'b1, "hold during entry")
   endtask : enter
   // The status word is never expected back; handler code saves it itself.
   task automatic leave(input logic [10:0] pc);
      instr(RET, 11'h000);
      `CHK(tk, 1'b0, "take on return")
      lat();
      `CHK(n, 4, "return cycles")
      `CHK(seq_o.pc_val, pc, "return address")
      `CHK(core_hold, 1'b1, "hold during return")
   endtask : leave
   task automatic t_regs();
      `CHK(seq_o.pc_val, cis_pkg::RESET_VEC, "reset vector")
      apb(1'b0, cis_pkg::A_STATUS, 32'h0);
      `CHK(rd[cis_pkg::GIE_BIT], 1'b0, "gie at reset")
      apb(1'b0, cis_pkg::A_STACK, 32'h0);
      `CHK(rd[15:0], cis_pkg::SP_RST, "stack at reset")
      apb(1'b0, 8'h1c, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0}, "unmapped read")
   endtask : t_regs
   task automatic t_flags();
      flag(8'h02);
      apb(1'b0, cis_pkg::A_FLAG, 32'h0);
      `CHK(rd[7:0], 8'h02, "flag lost while disabled")
      apb(1'b1, cis_pkg::A_FLAG, 32'h0);
      apb(1'b0, cis_pkg::A_FLAG, 32'h0);
      `CHK(rd[7:0], 8'h02, "zero write cleared")
      apb(1'b1, cis_pkg::A_FLAG, 32'h2);
      apb(1'b0, cis_pkg::A_FLAG, 32'h0);
      `CHK(rd[7:0], 8'h00, "one write kept")
   endtask : t_flags
   task automatic t_entry();
      apb(1'b1, cis_pkg::A_ENABLE, 32'h06);
      flag(8'h06);
      instr(DN, 11'h000);
      `CHK(tk, 1'b0, "take with gie 0")
      instr(SEI, 11'h000);
      `CHK(tk, 1'b0, "take on sei")
      enter(DN, 11'h5a3, 11'h002, 4);
      apb(1'b0, cis_pkg::A_STATUS, 32'h0);
      `CHK(rd[7], 1'b0, "gie kept on entry")
      apb(1'b0, cis_pkg::A_FLAG, 32'h0);
      `CHK(rd[7:0], 8'h04, "flag not cleared")
      apb(1'b0, cis_pkg::A_STACK, 32'h0);
      `CHK(rd[15:0], 16'h015d, "stack after push")
      apb(1'b0, cis_pkg::A_LAT, 32'h0);
      `CHK(rd, 32'(cis_pkg::ENTRY_CYC + cis_pkg::JUMP_CYC), "handler latency")
      leave(11'h5a3);
      apb(1'b0, cis_pkg::A_STATE, 32'h0);
      `CHK(rd, {21'h0, 11'h5a3}, "state after return")
      apb(1'b0, cis_pkg::A_STATUS, 32'h0);
      `CHK(rd[7], 1'b1, "gie after return")
      apb(1'b0, cis_pkg::A_STACK, 32'h0);
      `CHK(rd[15:0], 16'h015f, "stack after pop")
      enter(DN, 11'h123, 11'h003, 4);
   endtask : t_entry
   task automatic t_nest();
      flag(8'h02);
      instr(DN, 11'h000);
      `CHK(tk, 1'b0, "take inside handler")
      instr(SEI, 11'h000);
      enter(DN, 11'h456, 11'h002, 4);
      leave(11'h456);
      leave(11'h123);
   endtask : t_nest
   task automatic t_cli_sleep();
      flag(8'h02);
      instr(MSK, 11'h000);
      `CHK(tk, 1'b0, "take with global mask")
      instr(DN, 11'h000);
      `CHK(tk, 1'b0, "take after cli")
      instr(SEI, 11'h000);
      enter(SLP, 11'h7ff, 11'h002, 8);
      apb(1'b0, cis_pkg::A_LAT, 32'h0);
      `CHK(rd, 32'(cis_pkg::ENTRY_CYC + cis_pkg::SLEEP_EXTRA + cis_pkg::JUMP_CYC), "wake latency")
      leave(11'h7ff);
   endtask : t_cli_sleep
   task automatic t_level();
      apb(1'b1, cis_pkg::A_ENABLE, 32'h0);
      level_cond <= 8'h40;
      repeat (3) @(posedge mclk);
      level_cond <= 8'h00;
      apb(1'b1, cis_pkg::A_ENABLE, 32'h40);
      instr(DN, 11'h000);
      `CHK(tk, 1'b0, "vanished level taken")
      level_cond <= 8'h40;
      apb(1'b0, cis_pkg::A_LEVEL, 32'h0);
      `CHK(rd[7:0], 8'h40, "level view")
      enter(DN, 11'h0aa, 11'h007, 4);
      @(posedge mclk);
      level_cond <= 8'h00;
      leave(11'h0aa);
   endtask : t_level
   task automatic t_ext();
      apb(1'b1, cis_pkg::A_ENABLE, 32'h03);
      flag(8'h02);
      ext_req <= 1'b1;
      // Three synchroniser stages and the flag register need four cycles.
      repeat (4) begin
         @(negedge mclk);
         `CHK(seq_o.taken, 1'b0, "take off boundary")
      end
      enter(DN, 11'h321, 11'h001, 4);
      leave(11'h321);
      enter(DN, 11'h322, 11'h002, 4);
      leave(11'h322);
      ext_req <= 1'b0;
   endtask : t_ext
   initial begin
      {rst_n, psel, penable, pwrite, ext_req} = 5'h00;
      {paddr, pwdata, flag_evt, level_cond} = 56'h0;
      pipe_i = '0;
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      t_regs();
      t_flags();
      t_entry();
      t_nest();
      t_cli_sleep();
      t_level();
      t_ext();
      conclude();
   end
   initial begin
      repeat (5000) @(posedge mclk);
      mismatches++;
      conclude();
   end
endmodule : cis_sequencer_tb

/* File: bench/cis_stack_model.sv */
/*
 Behavioural stack memory on the far side of the sequencer.
 Assumes stack strobes from seq_o and a one cycle read latency.
*/
module cis_stack_model (
   input wire logic mclk,
   input wire cis_pkg::cis_seq_out_t seq_o,
   output logic [7:0] stk_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem_r [512];
   initial stk_rdata = 8'h00;
   // Outside a read the data toggles every cycle, so a stale byte taken late shows up.
   always @(posedge mclk) begin
      if (seq_o.stk_we)
         mem_r[seq_o.stk_addr[8:0]] <= seq_o.stk_wdata;
      stk_rdata <= seq_o.stk_re ? mem_r[seq_o.stk_addr[8:0]] : ~stk_rdata;
   end
endmodule : cis_stack_model

/* File: rtl/cis_pkg.sv */
/*
 Package of the interrupt and reset sequencer: register map, field positions,
 sequencing cycle counts, state encoding and the structs that carry the
 pipeline handshake. Assumes a single core clock domain and an APB master.
*/
package cis_pkg;
   localparam int PC_W = 11;
   localparam int SP_W = 16;
   localparam int CNT_W = 4;
   localparam int PA_W = 8;

   localparam logic [PA_W-1:0] A_STATUS = 8'h00;
   localparam logic [PA_W-1:0] A_FLAG = 8'h04;
   localparam logic [PA_W-1:0] A_ENABLE = 8'h08;
   localparam logic [PA_W-1:0] A_LEVEL = 8'h0c;
   localparam logic [PA_W-1:0] A_STACK = 8'h10;
   localparam logic [PA_W-1:0] A_STATE = 8'h14;
   localparam logic [PA_W-1:0] A_LAT = 8'h18;

   localparam int GIE_BIT = 7;
   localparam int BUSY_BIT = 31;
   localparam logic [SP_W-1:0] SP_RST = 16'h015f;
   localparam logic [PC_W-1:0] RESET_VEC = 11'h000;

   localparam logic [CNT_W-1:0] ENTRY_CYC = 4'h4;
   localparam logic [CNT_W-1:0] SLEEP_EXTRA = 4'h4;
   localparam logic [CNT_W-1:0] JUMP_CYC = 4'h3;
   localparam logic [CNT_W-1:0] RET_CYC = 4'h4;
   localparam logic [SP_W-1:0] PC_BYTES = 16'h0002;

   typedef enum logic [1:0] {
      CIS_RESET,
      CIS_IDLE,
      CIS_ENTRY,
      CIS_RET
   } cis_state_t;

   typedef struct packed {
      logic done;
      logic sei;
      logic global_mask_op;
      logic ret;
      logic asleep;
      logic [PC_W-1:0] pc;
   } cis_pipe_in_t;

   typedef struct packed {
      logic taken;
      logic pc_load;
      logic [PC_W-1:0] pc_val;
      logic stk_we;
      logic stk_re;
      logic [SP_W-1:0] stk_addr;
      logic [7:0] stk_wdata;
   } cis_seq_out_t;
endpackage : cis_pkg

/* File: rtl/cis_sequencer.sv */
/*
 Interrupt and reset sequencer of a small 8-bit core: pending flags, enables,
 priority, global enable handling, entry and return sequences with stack
 traffic. Assumes the pipeline pulses done at each instruction boundary,
 pulses sei/global_mask_op together with done of that instruction, pulses ret
 when the return instruction starts, and that stack reads answer one cycle later.
*/
// Decided for this implementation: the register offsets and the APB register port.
module cis_sequencer #(
   parameter int SRC = 8,
   parameter logic [SRC-1:0] LVL_MASK = 8'hc0
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [cis_pkg::PA_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic external_request_zero,
   input wire logic [SRC-1:0] flag_evt,
   input wire logic [SRC-1:0] level_cond,
   input wire cis_pkg::cis_pipe_in_t pipe_i,
   input wire logic [7:0] stk_rdata,
   output cis_pkg::cis_seq_out_t seq_o,
   output logic core_hold
);
   // The whole block runs on mclk, the undivided core clock.
   cis_pkg::cis_state_t state_r;
   logic [cis_pkg::CNT_W-1:0] cnt_r, len_r, lat_r;
   logic gie_r;
   logic [SRC-1:0] flag_r, en_r, pend, elig, fset, fclr;
   logic [cis_pkg::SP_W-1:0] sp_r;
   logic [cis_pkg::PC_W-1:0] ret_pc_r, pcv_r;
   logic [$clog2(SRC)-1:0] sel, sel_r;
   logic [7:0] hi_r;
   logic [2:0] ext_s;
   logic ext_lvl_r;
   logic take, last, wr, rd, st_wr;

   function automatic logic [$clog2(SRC)-1:0] top_pick(input logic [SRC-1:0] v);
      top_pick = '0;
      for (int i = SRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            top_pick = i[$clog2(SRC)-1:0];
         end
      end
   endfunction : top_pick

   function automatic logic [cis_pkg::PC_W-1:0] vec_of(input logic [$clog2(SRC)-1:0] s);
      vec_of = cis_pkg::RESET_VEC + cis_pkg::PC_W'(s) + 11'h001;
   endfunction : vec_of

   // The pin is synchronised; a level counts once the second and third stages agree.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ext_s <= 3'h0;
      end else begin
         ext_s <= {ext_s[1], ext_s[0], external_request_zero};
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ext_lvl_r <= 1'b0;
      end else if (ext_s[1] == ext_s[2]) begin
         ext_lvl_r <= ext_s[2];
      end
   end

   // Source zero is the external request, a rising edge sets its flag.
   assign fset = {flag_evt[SRC-1:1], (ext_s[1] & ext_s[2] & ~ext_lvl_r)} & ~LVL_MASK;

   assign wr = psel & penable & pwrite;
   assign rd = psel & ~penable & ~pwrite;
   assign st_wr = wr && paddr == cis_pkg::A_STATUS;

   assign pend = (flag_r & ~LVL_MASK) | (level_cond & LVL_MASK);
   assign elig = pend & en_r;
   assign sel = top_pick(elig);

   // Acceptance only at a completed instruction, with the registered enable so
   // that the instruction after a set of the enable always runs first. A clear
   // in the same cycle wins over any request.
   assign take = state_r == cis_pkg::CIS_IDLE && pipe_i.done && !pipe_i.ret &&
                 gie_r && !pipe_i.global_mask_op && |elig;
   assign last = cnt_r == len_r - 4'h1;
   assign core_hold = state_r != cis_pkg::CIS_IDLE;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_r <= cis_pkg::CIS_RESET;
         cnt_r <= '0;
         len_r <= '0;
      end else begin
         unique case (state_r)
            cis_pkg::CIS_RESET: begin
               state_r <= cis_pkg::CIS_IDLE;
            end
            cis_pkg::CIS_IDLE: begin
               cnt_r <= '0;
               if (take) begin
                  state_r <= cis_pkg::CIS_ENTRY;
                  len_r <= pipe_i.asleep ? cis_pkg::ENTRY_CYC + cis_pkg::SLEEP_EXTRA
                                         : cis_pkg::ENTRY_CYC;
               end else if (pipe_i.ret) begin
                  state_r <= cis_pkg::CIS_RET;
                  len_r <= cis_pkg::RET_CYC;
               end
            end
            cis_pkg::CIS_ENTRY, cis_pkg::CIS_RET: begin
               cnt_r <= cnt_r + 4'h1;
               if (last) begin
                  state_r <= cis_pkg::CIS_IDLE;
               end
            end
         endcase
      end
   end

   // Hardware and software clears combine; a new event wins over both.
   assign fclr = (wr && paddr == cis_pkg::A_FLAG ? pwdata[SRC-1:0] : '0) |
                 (take ? SRC'(1) << sel : '0);

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         flag_r <= '0;
      end else begin
         flag_r <= ((flag_r & ~fclr) | fset) & ~LVL_MASK;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         en_r <= '0;
      end else if (wr && paddr == cis_pkg::A_ENABLE) begin
         en_r <= pwdata[SRC-1:0];
      end
   end

   // Only the enable bit lives here; the rest of the status byte belongs to the
   // ALU and is never saved on entry, so handlers must keep it themselves.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         gie_r <= 1'b0;
      end else if (take || pipe_i.global_mask_op) begin
         gie_r <= 1'b0;
      end else if (state_r == cis_pkg::CIS_RET && last) begin
         gie_r <= 1'b1;
      end else if (pipe_i.sei) begin
         gie_r <= 1'b1;
      end else if (st_wr) begin
         gie_r <= pwdata[cis_pkg::GIE_BIT];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sp_r <= cis_pkg::SP_RST;
      end else if (state_r == cis_pkg::CIS_ENTRY && last) begin
         sp_r <= sp_r - cis_pkg::PC_BYTES;
      end else if (state_r == cis_pkg::CIS_RET && last) begin
         sp_r <= sp_r + cis_pkg::PC_BYTES;
      end else if (wr && paddr == cis_pkg::A_STACK) begin
         sp_r <= pwdata[cis_pkg::SP_W-1:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ret_pc_r <= '0;
         sel_r <= '0;
      end else if (take) begin
         ret_pc_r <= pipe_i.pc;
         sel_r <= sel;
      end
   end

   // Popped bytes: high byte answers in cycle one, low byte in cycle two.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         hi_r <= '0;
         pcv_r <= cis_pkg::RESET_VEC;
      end else if (state_r == cis_pkg::CIS_RET && cnt_r == 4'h1) begin
         hi_r <= stk_rdata;
      end else if (state_r == cis_pkg::CIS_RET && cnt_r == 4'h2) begin
         pcv_r <= {hi_r[cis_pkg::PC_W-9:0], stk_rdata};
      end else if (take) begin
         pcv_r <= vec_of(sel);
      end
   end

   // Cycles from acceptance to the handler, the vector jump included.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         lat_r <= '0;
      end else if (state_r == cis_pkg::CIS_ENTRY && last) begin
         lat_r <= len_r + cis_pkg::JUMP_CYC;
      end
   end

   always_comb begin
      seq_o = '0;
      seq_o.taken = take;
      seq_o.pc_val = pcv_r;
      // Reset ranks above all: the first cycle after reset loads its vector.
      seq_o.pc_load = state_r == cis_pkg::CIS_RESET ||
                      (state_r != cis_pkg::CIS_IDLE && last);
      if (state_r == cis_pkg::CIS_ENTRY && cnt_r < cis_pkg::CNT_W'(cis_pkg::PC_BYTES)) begin
         seq_o.stk_we = 1'b1;
         seq_o.stk_addr = sp_r - cis_pkg::SP_W'(cnt_r);
         seq_o.stk_wdata = cnt_r == '0 ? ret_pc_r[7:0]
                                       : 8'(ret_pc_r[cis_pkg::PC_W-1:8]);
      end
      if (state_r == cis_pkg::CIS_RET && cnt_r < cis_pkg::CNT_W'(cis_pkg::PC_BYTES)) begin
         seq_o.stk_re = 1'b1;
         seq_o.stk_addr = sp_r + cis_pkg::SP_W'(cnt_r) + 16'h0001;
      end
   end

   // Zero wait states; unmapped addresses answer with an error and zero data.
   assign pready = 1'b1;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         prdata <= '0;
         pslverr <= 1'b0;
      end else if (rd) begin
         pslverr <= 1'b0;
         unique case (paddr)
            cis_pkg::A_STATUS: prdata <= 32'(gie_r) << cis_pkg::GIE_BIT;
            cis_pkg::A_FLAG: prdata <= 32'(flag_r);
            cis_pkg::A_ENABLE: prdata <= 32'(en_r);
            cis_pkg::A_LEVEL: prdata <= 32'(level_cond & LVL_MASK);
            cis_pkg::A_STACK: prdata <= 32'(sp_r);
            cis_pkg::A_STATE: prdata <= {core_hold, 20'h0, pcv_r};
            cis_pkg::A_LAT: prdata <= 32'(lat_r);
            default: begin
               prdata <= '0;
               pslverr <= 1'b1;
            end
         endcase
      end else if (psel && !penable) begin
         prdata <= '0;
         pslverr <= !(paddr inside {cis_pkg::A_STATUS, cis_pkg::A_FLAG,
                      cis_pkg::A_ENABLE, cis_pkg::A_STACK});
      end
   end

   property p_gate;
      @(posedge mclk) disable iff (!rst_n) take |-> gie_r && en_r[sel];
   endproperty
   a_gate: assert property (p_gate) else $error("take without enables");

   property p_prio;
      @(posedge mclk) disable iff (!rst_n) take |-> (elig & ((SRC'(1) << sel) - SRC'(1))) == '0;
   endproperty
   a_prio: assert property (p_prio) else $error("lower vector skipped");

   property p_gie_clr;
      @(posedge mclk) disable iff (!rst_n) take |=> !gie_r [*4];
   endproperty
   a_gie_clr: assert property (p_gie_clr) else $error("enable not cleared");

   property p_ret;
      @(posedge mclk) disable iff (!rst_n)
         state_r == cis_pkg::CIS_IDLE && pipe_i.ret && !take |-> ##4 seq_o.pc_load ##1 gie_r;
   endproperty
   a_ret: assert property (p_ret) else $error("return sequence wrong");

   property p_hwclr;
      @(posedge mclk) disable iff (!rst_n)
         take && !LVL_MASK[sel] |=> !flag_r[sel_r] || $past(fset[sel]);
   endproperty
   a_hwclr: assert property (p_hwclr) else $error("flag kept after vector");

   property p_gmask;
      @(posedge mclk) disable iff (!rst_n) pipe_i.global_mask_op |-> !take ##1 !gie_r;
   endproperty
   a_gmask: assert property (p_gmask) else $error("taken after disable");

   property p_entry;
      @(posedge mclk) disable iff (!rst_n)
         take && !pipe_i.asleep |-> seq_o.pc_load == 1'b0 [*4] ##0 1'b1 ##1 seq_o.pc_load;
   endproperty
   a_entry: assert property (p_entry) else $error("entry not four cycles");

   property p_sleep;
      @(posedge mclk) disable iff (!rst_n) take && pipe_i.asleep |-> ##8 seq_o.pc_load;
   endproperty
   a_sleep: assert property (p_sleep) else $error("wake entry not eight");

   property p_sp;
      @(posedge mclk) disable iff (!rst_n)
         take && !pipe_i.asleep |-> ##5 sp_r == $past(sp_r, 5) - cis_pkg::PC_BYTES;
   endproperty
   a_sp: assert property (p_sp) else $error("stack pointer not lowered");

   // Entry writes the low byte at the stack pointer, then the high byte below it,
   // so that the return reads them back in the opposite order.
   property p_push;
      @(posedge mclk) disable iff (!rst_n)
         take |=> seq_o.stk_we && seq_o.stk_addr == sp_r &&
            seq_o.stk_wdata == $past(pipe_i.pc[7:0])
            ##1 seq_o.stk_we && seq_o.stk_addr == sp_r - 16'h0001 &&
            seq_o.stk_wdata == 8'($past(pipe_i.pc[10:8], 2));
   endproperty
   a_push: assert property (p_push) else $error("push bytes wrong");

   // Return reads the high byte first, then the low byte above it.
   property p_pop;
      @(posedge mclk) disable iff (!rst_n)
         state_r == cis_pkg::CIS_IDLE && pipe_i.ret && !take |=>
            seq_o.stk_re && seq_o.stk_addr == sp_r + 16'h0001
            ##1 seq_o.stk_re && seq_o.stk_addr == sp_r + 16'h0002;
   endproperty
   a_pop: assert property (p_pop) else $error("pop addresses wrong");

   property p_sp_ret;
      @(posedge mclk) disable iff (!rst_n)
         state_r == cis_pkg::CIS_IDLE && pipe_i.ret && !take |->
            ##5 sp_r == $past(sp_r, 5) + cis_pkg::PC_BYTES;
   endproperty
   a_sp_ret: assert property (p_sp_ret) else $error("stack pointer not raised");

   // The enable set by sei only counts from the next boundary on.
   property p_sei_wait;
      @(posedge mclk) disable iff (!rst_n) pipe_i.sei && !gie_r |-> !take;
   endproperty
   a_sei_wait: assert property (p_sei_wait) else $error("taken on enable set");

   // A level source only counts while its condition still stands.
   property p_level;
      @(posedge mclk) disable iff (!rst_n) take && LVL_MASK[sel] |-> level_cond[sel];
   endproperty
   a_level: assert property (p_level) else $error("level taken without cause");

   property p_hold;
      @(posedge mclk) disable iff (!rst_n) take |=> core_hold [*4];
   endproperty
   a_hold: assert property (p_hold) else $error("pipeline released in entry");

   c_take: cover property (@(posedge mclk) disable iff (!rst_n) take);
   c_nest: cover property (@(posedge mclk) disable iff (!rst_n)
      core_hold && state_r == cis_pkg::CIS_ENTRY ##[1:40] take);
   c_ret: cover property (@(posedge mclk) disable iff (!rst_n)
      state_r == cis_pkg::CIS_RET && last);
   c_sleep: cover property (@(posedge mclk) disable iff (!rst_n)
      take && pipe_i.asleep);
endmodule : cis_sequencer
